/* File: rtl/qpf_core.sv */
`timescale 1ns/100ps
module qpf_core
    import qpf_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // program memory
    output logic [PROG_AW-1:0]        prog_addr,
    input  wire logic [WORD_W-1:0]    prog_rdata,
    // phase strobes
    output logic                      phase_one,
    output logic                      phase_two,
    output logic                      phase_three,
    output logic                      phase_four,
    // instruction towards the decoder
    output logic [WORD_W-1:0]         instruction_holding_reg,
    output logic                      instr_valid,
    // decoder requests for the executing word
    input  wire logic [OFS_W-1:0]     exe_file_addr,
    input  wire logic                 exe_file_wr,
    input  wire logic [DATA_W-1:0]    exe_wr_data,
    input  wire logic                 exe_flags_wr,
    input  wire logic [2:0]           exe_flags,
    input  wire logic                 exe_jump,
    input  wire logic [JUMP_W-1:0]    exe_jump_addr,
    input  wire logic                 vector_req,
    // results and state
    output logic [DATA_W-1:0]         operand_data,
    output logic [PC_W-1:0]           program_counter,
    output logic [DATA_W-1:0]         bank_and_flags_reg,
    output logic [DATA_W-1:0]         intr_ctrl_reg
);

    // phase ring and fetch side
    logic [NPHASE-1:0]   phase_ring;
    logic [PC_W-1:0]     pc_reg;
    logic [PC_W-1:0]     pc_next;
    logic [PROG_AW-1:0]  fetch_addr_reg;
    logic [WORD_W-1:0]   fetch_word_reg;
    logic                fetch_ok_reg;

    // execute side
    logic [WORD_W-1:0]   ir_reg;
    logic                ir_valid_reg;
    logic [DATA_W-1:0]   operand_reg;

    // core special registers
    logic [DATA_W-1:0]   status_reg;
    logic [DATA_W-1:0]   pointer_reg;
    logic [LATCH_W-1:0]  latch_reg;
    logic [DATA_W-1:0]   intctl_reg;

    // register file access
    logic [FADDR_W-1:0]  eff_addr;
    logic [DATA_W-1:0]   core_rd_data;
    logic                core_rd_hit;
    logic [DATA_W-1:0]   gpr_rd_data;
    logic                gpr_rd_hit;
    logic [DATA_W-1:0]   file_rd_data;

    // write strobes, all qualified at phase four; the reload request is computed every clock
    logic                do_write;
    logic                pcl_write;
    logic                status_write;
    logic                pointer_write;
    logic                latch_write;
    logic                intctl_write;
    logic                flags_write;
    logic                pc_change;

    // one instruction cycle is four clocks:
    //   phase one   pc steps, fetch address latched, holding register loads
    //   phase two   operand read from the resolved file address
    //   phase three decode settles in the outside decoder, nothing latched here
    //   phase four  result and flags written, pc reloaded, program word caught
    // a reload at phase four leaves the caught word stale; it still loads at
    // the next phase one, but with its valid bit low, so it runs as a no-op

    // phase ring: one clock per phase, four clocks per instruction cycle
    qpf_phase_gen #(
        .NUM_PHASE (NPHASE)
    ) u_phase (
        .clk        (clk),
        .resetn     (resetn),
        .phase_ring (phase_ring)
    );

    assign phase_one   = phase_ring[0];
    assign phase_two   = phase_ring[1];
    assign phase_three = phase_ring[2];
    assign phase_four  = phase_ring[3];

    // direct offset 00h redirects through the pointer; banks from status or pointer
    function automatic logic [FADDR_W-1:0] resolve(
        input logic [OFS_W-1:0]  ofs,
        input logic [DATA_W-1:0] st,
        input logic [DATA_W-1:0] ptr
    );
        if (ofs == OFS_INDIRECT) begin
            resolve = {st[ST_IRP], ptr};
        end else begin
            resolve = {st[ST_RP1], st[ST_RP0], ofs};
        end
    endfunction

    // low-offset match; used by every core register write strobe
    function automatic logic on_offset(
        input logic [FADDR_W-1:0] ea,
        input logic [OFS_W-1:0]   ofs
    );
        on_offset = (ea[OFS_W-1:0] == ofs);
    endfunction

    // the indirect bank bit and upper bank bit are honoured, but reach only banks 2 and 3, which hold no RAM, only the mirrored core registers
    assign eff_addr = resolve(exe_file_addr, status_reg, pointer_reg);

    // core special registers decode on the low offset only, so every bank sees them
    // peripheral offsets fall to the default and read as zero here
    always_comb begin
        core_rd_hit  = 1'b1;
        core_rd_data = BYTE_ZERO;
        case (eff_addr[OFS_W-1:0])
            OFS_INDIRECT: core_rd_data = BYTE_ZERO;
            OFS_PCL:      core_rd_data = pc_reg[DATA_W-1:0];
            OFS_STATUS:   core_rd_data = status_reg;
            OFS_POINTER:  core_rd_data = pointer_reg;
            OFS_PROGRAM_COUNTER_UPPER_LATCH:   core_rd_data = {3'h0, latch_reg};
            OFS_INTCTL:   core_rd_data = intctl_reg;
            default:      core_rd_hit  = 1'b0;
        endcase
    end

    // general purpose RAM, banks 0 and 1 only
    qpf_gpr_ram #(
        .PER_BANK (GPR_PER_BANK),
        .BANKS    (GPR_BANKS)
    ) u_gpr (
        .clk     (clk),
        .rd_addr (eff_addr),
        .rd_data (gpr_rd_data),
        .rd_hit  (gpr_rd_hit),
        .wr_en   (do_write),
        .wr_addr (eff_addr),
        .wr_data (exe_wr_data)
    );

    // flushed words never write; that is what makes them a no-operation
    assign do_write  = phase_four && ir_valid_reg && exe_file_wr;
    assign pcl_write = do_write && on_offset(eff_addr, OFS_PCL);

    // one strobe per core register; offset only, so any bank reaches them
    assign status_write  = do_write && on_offset(eff_addr, OFS_STATUS);
    assign pointer_write = do_write && on_offset(eff_addr, OFS_POINTER);
    assign latch_write   = do_write && on_offset(eff_addr, OFS_PROGRAM_COUNTER_UPPER_LATCH);
    assign intctl_write  = do_write && on_offset(eff_addr, OFS_INTCTL);
    assign flags_write   = phase_four && ir_valid_reg && exe_flags_wr;

    // next program counter, chosen at phase four; vector beats the executing word
    // computed every clock but only applied while phase four is high
    always_comb begin
        pc_change = 1'b0;
        pc_next   = pc_reg;
        if (vector_req) begin
            pc_change = 1'b1;
            pc_next   = INTR_VECTOR;
        end else if (ir_valid_reg && exe_jump) begin
            pc_change = 1'b1;
            pc_next   = {latch_reg[LATCH_W-1:LATCH_W-2], exe_jump_addr};
        end else if (pcl_write) begin
            pc_change = 1'b1;
            pc_next   = {latch_reg, exe_wr_data};
        end
    end

    // program counter: step in phase one, reload in phase four
    // the reload lands three clocks after the step, so it always wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_reg <= RESET_VECTOR;
        end else if (phase_one) begin
            pc_reg <= pc_reg + PC_STEP;
        end else if (phase_four && pc_change) begin
            pc_reg <= pc_next;
        end
    end

    // fetch address held for the whole cycle; top bit dropped so 1000h wraps to 0000h
    // holding it keeps a phase four reload away from the word in flight
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_addr_reg <= RESET_VECTOR[PROG_AW-1:0];
        end else if (phase_one) begin
            fetch_addr_reg <= pc_reg[PROG_AW-1:0];
        end
    end

    assign prog_addr = fetch_addr_reg;

    // fetched word captured at the end of the cycle; a reload marks it stale
    // the stale word still moves on; only its valid bit drops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_word_reg <= WORD_ZERO;
            fetch_ok_reg   <= 1'b0;
        end else if (phase_four) begin
            fetch_word_reg <= prog_rdata;
            fetch_ok_reg   <= !pc_change;
        end
    end

    // holding register loads at phase one, overlapping the next fetch
    // a low valid bit blocks every write, jump and flag update of the word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ir_reg       <= WORD_ZERO;
            ir_valid_reg <= 1'b0;
        end else if (phase_one) begin
            ir_reg       <= fetch_word_reg;
            ir_valid_reg <= fetch_ok_reg;
        end
    end

    assign instruction_holding_reg = ir_reg;
    assign instr_valid             = ir_valid_reg;

    // operand source: core register first, then RAM, else zero
    always_comb begin
        if (core_rd_hit) begin
            file_rd_data = core_rd_data;
        end else if (gpr_rd_hit) begin
            file_rd_data = gpr_rd_data;
        end else begin
            file_rd_data = BYTE_ZERO;
        end
    end

    // operand read at phase two; held until the next phase two
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            operand_reg <= BYTE_ZERO;
        end else if (phase_two) begin
            operand_reg <= file_rd_data;
        end
    end

    assign operand_data = operand_reg;

    // status: bank and flag bits writable, timeout and power-down bits read only;
    // flag results of the instruction win over a plain write of the same byte
    // timeout and power-down are set only by the reset value STATUS_RESET in this block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= STATUS_RESET;
        end else begin
            if (status_write) begin
                status_reg[ST_IRP] <= exe_wr_data[ST_IRP];
                status_reg[ST_RP1] <= exe_wr_data[ST_RP1];
                status_reg[ST_RP0] <= exe_wr_data[ST_RP0];
                status_reg[ST_Z]   <= exe_wr_data[ST_Z];
                status_reg[ST_DC]  <= exe_wr_data[ST_DC];
                status_reg[ST_C]   <= exe_wr_data[ST_C];
            end
            if (flags_write) begin
                status_reg[ST_Z:ST_C] <= exe_flags;
            end
        end
    end

    assign bank_and_flags_reg = status_reg;

    // indirect pointer
    // with the indirect bank bit it reaches the whole 9-bit file
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pointer_reg <= BYTE_ZERO;
        end else if (pointer_write) begin
            pointer_reg <= exe_wr_data;
        end
    end

    // upper program counter latch, only five bits stored
    // reads back with its upper three bits as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_reg <= LATCH_ZERO;
        end else if (latch_write) begin
            latch_reg <= exe_wr_data[LATCH_W-1:0];
        end
    end

    // interrupt control byte is stored here; its meaning lives elsewhere
    // no interrupt logic here: vector_req arrives already decided
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intctl_reg <= BYTE_ZERO;
        end else if (intctl_write) begin
            intctl_reg <= exe_wr_data;
        end
    end

    assign intr_ctrl_reg   = intctl_reg;
    assign program_counter = pc_reg;

endmodule

/* File: rtl/qpf_pkg.sv */
// How it works
// - The input clock is divided by four into four non-overlapping phases that make one instruction cycle.
// - A fetch advances the program counter in phase one and captures the program word in phase four.
// - Fetch of the next word overlaps decode and execution of the current one, one instruction per cycle.
// - A change of the program counter flushes the fetched word, so that instruction takes two cycles.
// - The instruction enters the holding register in phase one and executes over phases two to four.
// - The data memory operand is read in phase two and the result is written in phase four.
// - The program counter is 13 bits wide, covering an 8K word space of 14-bit words.
// - Only 4K words exist at 0000h to 0FFFh and any higher address wraps into that range.
// - Execution starts at 0000h after reset and an interrupt vectors to 0004h.
// - Status bits 6 and 5 select data bank 0 to 3.
// - Each bank spans offsets up to 7Fh, 128 bytes, with the special registers at the bottom.
// - General purpose RAM sits at 20h to 7Fh in bank 0 and A0h to FFh in bank 1.
// - The core special registers are mirrored at the same offset in every bank.
// - The file is reached directly or through the indirect pointer, and offset 00h is no real register.
// - Any unimplemented data memory location reads as zero.
package qpf_pkg;

    // widths
    localparam int PC_W      = 13;
    localparam int PROG_AW   = 12;
    localparam int WORD_W    = 14;
    localparam int DATA_W    = 8;
    localparam int OFS_W     = 7;
    localparam int FADDR_W   = 9;
    localparam int JUMP_W    = 11;
    localparam int LATCH_W   = 5;
    localparam int NPHASE    = 4;

    // program memory vectors
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] INTR_VECTOR  = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP      = 13'h0001;

    // core special register offsets, mirrored in every bank
    localparam logic [OFS_W-1:0] OFS_INDIRECT = 7'h00;
    localparam logic [OFS_W-1:0] OFS_PCL      = 7'h02;
    localparam logic [OFS_W-1:0] OFS_STATUS   = 7'h03;
    localparam logic [OFS_W-1:0] OFS_POINTER  = 7'h04;
    localparam logic [OFS_W-1:0] OFS_PROGRAM_COUNTER_UPPER_LATCH   = 7'h0A;
    localparam logic [OFS_W-1:0] OFS_INTCTL   = 7'h0B;

    // general purpose RAM window within a bank
    localparam logic [OFS_W-1:0] GPR_FIRST    = 7'h20;
    localparam int               GPR_PER_BANK = 96;
    localparam int               GPR_BANKS    = 2;

    // status bit positions
    localparam int ST_IRP = 7;
    localparam int ST_RP1 = 6;
    localparam int ST_RP0 = 5;
    localparam int ST_TO  = 4;
    localparam int ST_PD  = 3;
    localparam int ST_Z   = 2;
    localparam int ST_DC  = 1;
    localparam int ST_C   = 0;

    // reset values
    localparam logic [DATA_W-1:0]  STATUS_RESET = 8'h18;
    localparam logic [DATA_W-1:0]  BYTE_ZERO    = 8'h00;
    localparam logic [WORD_W-1:0]  WORD_ZERO    = 14'h0000;
    localparam logic [LATCH_W-1:0] LATCH_ZERO   = 5'h00;
    localparam logic [NPHASE-1:0]  PHASE_RESET  = 4'h1;

endpackage

/* File: rtl/qpf_phase_gen.sv */
`timescale 1ns/100ps
module qpf_phase_gen
    import qpf_pkg::*;
#(
    parameter int NUM_PHASE = NPHASE
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    output logic [NUM_PHASE-1:0]      phase_ring
);

    // one-hot ring: exactly one phase high per clock, so phases never overlap
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_ring <= NUM_PHASE'(PHASE_RESET);
        end else begin
            phase_ring <= {phase_ring[NUM_PHASE-2:0], phase_ring[NUM_PHASE-1]};
        end
    end

endmodule

/* File: rtl/qpf_gpr_ram.sv */
`timescale 1ns/100ps
module qpf_gpr_ram
    import qpf_pkg::*;
#(
    parameter int PER_BANK = GPR_PER_BANK,
    parameter int BANKS    = GPR_BANKS
) (
    input  wire logic                 clk,
    input  wire logic [FADDR_W-1:0]   rd_addr,
    output logic [DATA_W-1:0]         rd_data,
    output logic                      rd_hit,
    input  wire logic                 wr_en,
    input  wire logic [FADDR_W-1:0]   wr_addr,
    input  wire logic [DATA_W-1:0]    wr_data
);

    localparam int DEPTH = PER_BANK * BANKS;
    localparam int IDX_W = $clog2(DEPTH);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [IDX_W-1:0]  rd_idx;
    logic [IDX_W-1:0]  wr_idx;
    logic              wr_hit;

    // bank and offset to array index; misses cover the special area and absent banks
    function automatic logic [IDX_W:0] gpr_map(input logic [FADDR_W-1:0] a);
        logic [1:0]       bank;
        logic [OFS_W-1:0] ofs;
        int               idx;
        bank = a[FADDR_W-1:OFS_W];
        ofs  = a[OFS_W-1:0];
        idx  = int'(bank) * PER_BANK + int'(ofs) - int'(GPR_FIRST);
        if (int'(bank) < BANKS && ofs >= GPR_FIRST) begin
            gpr_map = {1'b1, IDX_W'(idx)};
        end else begin
            gpr_map = {1'b0, {IDX_W{1'b0}}};
        end
    endfunction

    assign {rd_hit, rd_idx} = gpr_map(rd_addr);
    assign {wr_hit, wr_idx} = gpr_map(wr_addr);

    // unmapped reads give zero
    assign rd_data = rd_hit ? mem[rd_idx] : BYTE_ZERO;

    // static RAM, no reset: contents are undefined at power-up
    always_ff @(posedge clk) begin
        if (wr_en && wr_hit) begin
            mem[wr_idx] <= wr_data;
        end
    end

endmodule

/* File: bench/qpf_core_asserts.sv */
`timescale 1ns/100ps
module qpf_core_asserts
    import qpf_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [PROG_AW-1:0]   prog_addr,
    input wire logic [WORD_W-1:0]    prog_rdata,
    input wire logic                 phase_one,
    input wire logic                 phase_two,
    input wire logic                 phase_three,
    input wire logic                 phase_four,
    input wire logic [WORD_W-1:0]    instruction_holding_reg,
    input wire logic                 instr_valid,
    input wire logic [OFS_W-1:0]     exe_file_addr,
    input wire logic                 exe_file_wr,
    input wire logic [DATA_W-1:0]    exe_wr_data,
    input wire logic                 exe_flags_wr,
    input wire logic [2:0]           exe_flags,
    input wire logic                 exe_jump,
    input wire logic [JUMP_W-1:0]    exe_jump_addr,
    input wire logic                 vector_req,
    input wire logic [DATA_W-1:0]    operand_data,
    input wire logic [PC_W-1:0]      program_counter,
    input wire logic [DATA_W-1:0]    bank_and_flags_reg,
    input wire logic [DATA_W-1:0]    intr_ctrl_reg
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // phase ring and fetch timing
    a_phase_onehot: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
        else $error("phase strobes not one-hot");
    a_phase_ring_order: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
        else $error("phase order broken");
    a_fetch_addr_load: assert property (phase_one |=> prog_addr == $past(program_counter[PROG_AW-1:0]))
        else $error("fetch address not taken from pc");
    a_pc_step_one: assert property (phase_one |=> program_counter == $past(program_counter) + PC_STEP)
        else $error("pc not advanced in phase one");
    a_fetch_addr_hold: assert property (phase_two |=> $stable(prog_addr) [*2])
        else $error("fetch address moved mid fetch");
    // executing word only moves at the end of phase one
    a_ir_phase_hold: assert property (!phase_one |=> $stable(instruction_holding_reg) && $stable(instr_valid))
        else $error("instruction register moved outside phase one");
    a_operand_read_time: assert property (!phase_two |=> $stable(operand_data))
        else $error("operand changed outside phase two");
    a_jump_target: assert property (phase_four && instr_valid && exe_jump && !vector_req
        |=> program_counter[JUMP_W-1:0] == $past(exe_jump_addr))
        else $error("jump target not loaded");
    a_flush_two_cycles: assert property (phase_four && (vector_req || (instr_valid && exe_jump))
        |=> ##1 !instr_valid ##4 instr_valid)
        else $error("flush slot wrong");
    a_vector_target: assert property (phase_four && vector_req
        |=> program_counter == INTR_VECTOR ##1 prog_addr == INTR_VECTOR[PROG_AW-1:0])
        else $error("vector not taken");
    // a flushed slot leaves state alone
    a_flush_no_effect: assert property (phase_four && !instr_valid && !vector_req
        |=> $stable(bank_and_flags_reg) && $stable(intr_ctrl_reg) && $stable(program_counter))
        else $error("flushed word changed state");
endmodule

bind qpf_core qpf_core_asserts qpf_core_asserts_inst (.clk(clk), .resetn(resetn),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .phase_one(phase_one),
    .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four),
    .instruction_holding_reg(instruction_holding_reg), .instr_valid(instr_valid),
    .exe_file_addr(exe_file_addr), .exe_file_wr(exe_file_wr), .exe_wr_data(exe_wr_data),
    .exe_flags_wr(exe_flags_wr), .exe_flags(exe_flags), .exe_jump(exe_jump),
    .exe_jump_addr(exe_jump_addr), .vector_req(vector_req), .operand_data(operand_data),
    .program_counter(program_counter), .bank_and_flags_reg(bank_and_flags_reg),
    .intr_ctrl_reg(intr_ctrl_reg));

/* File: bench/qpf_core_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module qpf_core_tb;
    import qpf_pkg::*;
    logic                clk, resetn, phase_one, phase_two, phase_three, phase_four;
    logic [PROG_AW-1:0]  prog_addr;
    logic [WORD_W-1:0]   prog_rdata, instruction_holding_reg, ir;
    logic                instr_valid, exe_file_wr, exe_flags_wr, exe_jump, vector_req, iv;
    logic [OFS_W-1:0]    exe_file_addr, a;
    logic [DATA_W-1:0]   exe_wr_data, operand_data, bank_and_flags_reg, intr_ctrl_reg, rd, d;
    logic [2:0]          exe_flags, fl;
    logic [JUMP_W-1:0]   exe_jump_addr, ja;
    logic [PC_W-1:0]     program_counter, pc_s;
    int                  n_fail = 0;
    int                  compares = 0;

    qpf_core qpf_core_inst (.clk(clk), .resetn(resetn), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .phase_one(phase_one), .phase_two(phase_two),
        .phase_three(phase_three), .phase_four(phase_four),
        .instruction_holding_reg(instruction_holding_reg), .instr_valid(instr_valid),
        .exe_file_addr(exe_file_addr), .exe_file_wr(exe_file_wr), .exe_wr_data(exe_wr_data),
        .exe_flags_wr(exe_flags_wr), .exe_flags(exe_flags), .exe_jump(exe_jump),
        .exe_jump_addr(exe_jump_addr), .vector_req(vector_req), .operand_data(operand_data),
        .program_counter(program_counter), .bank_and_flags_reg(bank_and_flags_reg),
        .intr_ctrl_reg(intr_ctrl_reg));

    // program word carries its own address so every fetch is traceable
    function automatic logic [WORD_W-1:0] word_of(input logic [PROG_AW-1:0] adr);
        return {2'h2, adr};
    endfunction

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // program memory answers on the falling edge, long before phase four ends
    always @(negedge clk) prog_rdata <= word_of(prog_addr);

    // one instruction slot: levels held from phase one past the phase four edge
    task automatic exec(input logic [6:0] o, input logic w, input logic [7:0] wd, input logic fw,
                        input logic [2:0] f, input logic j, input logic [10:0] jad, input logic v);
        int g = 0;
        while (!phase_one && g < 8) begin
            @(negedge clk);
            g++;
        end
        exe_file_addr = o;
        exe_file_wr = w;
        exe_wr_data = wd;
        exe_flags_wr = fw;
        exe_flags = f;
        exe_jump = j;
        exe_jump_addr = jad;
        vector_req = v;
        @(negedge clk);
        iv = instr_valid;
        ir = instruction_holding_reg;
        pc_s = program_counter;
        @(negedge clk);
        rd = operand_data;
        repeat (2) @(negedge clk);
    endtask

    task automatic wr_f(input logic [6:0] o, input logic [7:0] wd);
        exec(o, 1'b1, wd, 1'b0, 3'h0, 1'b0, 11'h000, 1'b0);
    endtask

    task automatic rd_f(input logic [6:0] o);
        exec(o, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, 11'h000, 1'b0);
    endtask

    // redirect, then a flushed slot that tries to write, then the target word
    task automatic redirect(input logic [6:0] o, input logic w, input logic [7:0] wd,
                            input logic j, input logic [10:0] jad, input logic v,
                            input logic [PROG_AW-1:0] tgt);
        exec(o, w, wd, 1'b0, 3'h0, j, jad, v);
        exec(7'h21, 1'b1, 8'hEE, 1'b1, 3'h0, 1'b0, 11'h000, 1'b0);
        `CHK("flush_valid", 1'b0, iv)
        rd_f(7'h21);
        `CHK("target_word", word_of(tgt), ir)
        `CHK("flushed_write", 8'h11, rd)
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog well beyond the 75 slots, about 300 clocks, of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        resetn = 1'b0;
        exe_file_addr = 7'h00; exe_file_wr = 1'b0; exe_wr_data = 8'h00; exe_flags_wr = 1'b0;
        exe_flags = 3'h0; exe_jump = 1'b0; exe_jump_addr = 11'h000; vector_req = 1'b0;
        void'($urandom(55589));
        repeat (5) @(negedge clk);
        `CHK("reset_pc", RESET_VECTOR, program_counter)
        `CHK("reset_status", 8'h18, bank_and_flags_reg)
        resetn = 1'b1;
        // word 0 first, then one word per slot
        for (int k = 0; k < 4; k++) begin
            rd_f(OFS_POINTER);
            if (k > 0) `CHK("pipeline_word", word_of(12'(k - 1)), ir)
        end
        // banking, mirrors, indirect access; keep indirect bank bit clear
        wr_f(OFS_STATUS, 8'h20);
        wr_f(7'h20, 8'hA5);
        wr_f(OFS_STATUS, 8'h07);
        rd_f(OFS_STATUS);
        `CHK("status_rw", 8'h1F, rd)
        wr_f(7'h20, 8'h5A);
        rd_f(7'h20);
        `CHK("bank0_ram", 8'h5A, rd)
        wr_f(OFS_POINTER, 8'hA0);
        rd_f(OFS_INDIRECT);
        `CHK("indirect_bank1", 8'hA5, rd)
        wr_f(OFS_STATUS, 8'h20);
        rd_f(7'h20);
        `CHK("bank1_ram", 8'hA5, rd)
        rd_f(OFS_POINTER);
        `CHK("mirror_bank1", 8'hA0, rd)
        wr_f(OFS_INTCTL, 8'hC3);
        wr_f(7'h0C, 8'h77);
        rd_f(7'h0C);
        `CHK("bank1_sfr_absent", 8'h00, rd)
        rd_f(OFS_STATUS);
        `CHK("mirror_status", 8'h38, rd)
        wr_f(OFS_STATUS, 8'h00);
        wr_f(OFS_POINTER, 8'h00);
        rd_f(OFS_INDIRECT);
        `CHK("indirect_self", 8'h00, rd)
        rd_f(7'h05);
        `CHK("unmapped_zero", 8'h00, rd)
        rd_f(OFS_INTCTL);
        `CHK("intctl_mirror", 8'hC3, rd)
        `CHK("intctl_port", 8'hC3, intr_ctrl_reg)
        // random traffic over bank 0 RAM, read back the next slot
        for (int i = 0; i < 16; i++) begin
            a = 7'h20 + 7'($urandom_range(95));
            d = 8'($urandom);
            wr_f(a, d);
            rd_f(a);
            `CHK("ram_readback", d, rd)
        end
        fl = 3'($urandom);
        exec(7'h05, 1'b0, 8'h00, 1'b1, fl, 1'b0, 11'h000, 1'b0);
        rd_f(OFS_STATUS);
        `CHK("flags_write", {5'h03, fl}, rd)
        // jumps, wrap above 0FFFh, program counter low write, vector
        wr_f(7'h21, 8'h11);
        ja = 11'($urandom);
        redirect(7'h05, 1'b0, 8'h00, 1'b1, ja, 1'b0, {1'b0, ja});
        wr_f(OFS_PROGRAM_COUNTER_UPPER_LATCH, 8'hF0);
        rd_f(OFS_PROGRAM_COUNTER_UPPER_LATCH);
        `CHK("latch_read", 8'h10, rd)
        redirect(7'h05, 1'b0, 8'h00, 1'b1, 11'h005, 1'b0, 12'h005);
        `CHK("wide_pc", 13'h1007, pc_s)
        redirect(OFS_PCL, 1'b1, 8'h33, 1'b0, 11'h000, 1'b0, 12'h033);
        rd_f(OFS_PCL);
        `CHK("pcl_read", 8'h36, rd)
        redirect(7'h05, 1'b0, 8'h00, 1'b0, 11'h000, 1'b1, INTR_VECTOR[PROG_AW-1:0]);
        rd_f(7'h05);
        print_verdict();
    end
endmodule
